// ===== design/dcs_pkg.sv
// constants, command codes and states of the ddr2 command sequencer
package dcs_pkg;
  localparam int unsigned DCS_ADDR_W = 13;
  localparam int unsigned DCS_BA_W = 3;
  localparam int unsigned DCS_NUM_BANKS = 8;
  localparam int unsigned DCS_AP_BIT = 10;
  localparam int unsigned DCS_BURST_LEN = 8;
  localparam int unsigned DCS_BEATS_PER_CLK = 2;
  localparam int unsigned DCS_BURST_CLK = DCS_BURST_LEN / DCS_BEATS_PER_CLK;
  localparam int unsigned DCS_CL_MIN = 2;
  localparam int unsigned DCS_CL_MAX = 5;
  localparam int unsigned DCS_DQM_W = 4;
  // command word order: select, row strobe, column strobe, write strobe
  localparam logic [3:0] DCS_CMD_NOP = 4'h7;
  localparam logic [3:0] DCS_CMD_DESEL = 4'hf;
  localparam logic [3:0] DCS_CMD_ACT = 4'h3;
  localparam logic [3:0] DCS_CMD_PRE = 4'h2;
  localparam logic [3:0] DCS_CMD_MRS = 4'h0;
  localparam logic [3:0] DCS_CMD_RD = 4'h5;
  localparam logic [3:0] DCS_CMD_WR = 4'h4;
  localparam logic [3:0] DCS_CMD_REF = 4'h1;
  // mode register contents
  localparam logic [2:0] DCS_MR_SEL = 3'h0;
  localparam logic [2:0] DCS_EMR_SEL = 3'h1;
  localparam logic [2:0] DCS_MR_BL8 = 3'h3;
  localparam int unsigned DCS_MR_CL_LSB = 4;
  localparam logic [2:0] DCS_EMR_AL = 3'h0;
  localparam int unsigned DCS_EMR_AL_LSB = 3;
  // memory timing in ns and cycles, counter widths
  localparam int unsigned DCS_T_RCD_NS = 15;
  localparam int unsigned DCS_T_RP_NS = 15;
  localparam int unsigned DCS_T_RFC_NS = 128;
  localparam int unsigned DCS_T_XSR_NS = 200;
  localparam int unsigned DCS_T_MRD_CYC = 2;
  localparam int unsigned DCS_T_XP_CYC = 2;
  localparam int unsigned DCS_CNT_W = 8;
  localparam int unsigned DCS_REF_W = 13;
  typedef enum logic [12:0] {
    DCS_ST_RST_PALL = 13'h0001,
    DCS_ST_MRS = 13'h0002,
    DCS_ST_EMRS = 13'h0004,
    DCS_ST_INIT_PALL = 13'h0008,
    DCS_ST_IDLE = 13'h0010,
    DCS_ST_REF_PALL = 13'h0020,
    DCS_ST_REF = 13'h0040,
    DCS_ST_SELF = 13'h0080,
    DCS_ST_PDN = 13'h0100,
    DCS_ST_PRE_ONE = 13'h0200,
    DCS_ST_ACT = 13'h0400,
    DCS_ST_XFER = 13'h0800,
    DCS_ST_WAIT = 13'h1000
  } dcs_state_t;
endpackage

// ===== design/dcs_sequencer.sv
// ddr2 command sequencer: request crossing, command fsm, page table, data windows
`timescale 1ns/100ps
`default_nettype none
module dcs_sequencer
  import dcs_pkg::*;
#(
  parameter int unsigned MCLK_PERIOD_NS = 160
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [DCS_BA_W-1:0] req_bank,
  input wire logic [DCS_ADDR_W-1:0] req_row,
  input wire logic [DCS_ADDR_W-1:0] req_col,
  input wire logic [3:0] req_words,
  input wire logic [DCS_DQM_W-1:0] req_byte_en,
  input wire logic self_refresh_req,
  input wire logic power_down_req,
  output logic init_done,
  input wire logic mclk,
  input wire logic [2:0] cas_latency,
  input wire logic [DCS_REF_W-1:0] refresh_interval,
  output logic mem_clock_out,
  output logic mem_cke,
  output logic mem_cs_n,
  output logic mem_ras_n,
  output logic mem_cas_n,
  output logic mem_we_n,
  output logic [DCS_BA_W-1:0] bank_select,
  output logic [DCS_ADDR_W-1:0] mem_addr,
  output logic [DCS_DQM_W-1:0] mem_dqm_rise,
  output logic [DCS_DQM_W-1:0] mem_dqm_fall,
  output logic mem_dq_oe,
  output logic mem_wdata_req,
  output logic [2:0] mem_beat_idx,
  output logic mem_rd_valid,
  output logic [1:0] mem_rd_keep,
  output logic mem_self_refresh
);
  localparam int unsigned RCD_CYC = (DCS_T_RCD_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int unsigned RP_CYC = (DCS_T_RP_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int unsigned RFC_CYC = (DCS_T_RFC_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int unsigned XSR_CYC = (DCS_T_XSR_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam logic [DCS_CNT_W-1:0] RCD_GAP = DCS_CNT_W'((RCD_CYC < 1) ? 1 : RCD_CYC);
  localparam logic [DCS_CNT_W-1:0] RP_GAP = DCS_CNT_W'((RP_CYC < 1) ? 1 : RP_CYC);
  localparam logic [DCS_CNT_W-1:0] RFC_GAP = DCS_CNT_W'((RFC_CYC < 1) ? 1 : RFC_CYC);
  localparam logic [DCS_CNT_W-1:0] XSR_GAP = DCS_CNT_W'((XSR_CYC < 1) ? 1 : XSR_CYC);
  localparam logic [DCS_CNT_W-1:0] MRD_GAP = DCS_CNT_W'(DCS_T_MRD_CYC);
  localparam logic [DCS_CNT_W-1:0] XP_GAP = DCS_CNT_W'(DCS_T_XP_CYC);
  localparam logic [DCS_CNT_W-1:0] GAP_ONE = DCS_CNT_W'(1);
  localparam logic [4:0] BURST_CLK5 = 5'(DCS_BURST_CLK);
  // ==========================================================
  // system side: request hold and toggle handshake
  logic req_tgl_r;
  logic ack_s1_r;
  logic ack_s2_r;
  logic h_write_r;
  logic [DCS_BA_W-1:0] h_bank_r;
  logic [DCS_ADDR_W-1:0] h_row_r;
  logic [DCS_ADDR_W-1:0] h_col_r;
  logic [3:0] h_words_r;
  logic [DCS_DQM_W-1:0] h_be_r;
  logic init_s1_r;
  logic init_s2_r;
  logic ack_tgl_r;
  logic init_done_m_r;
  assign req_ready = (ack_s2_r == req_tgl_r);
  assign init_done = init_s2_r;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
      init_s1_r <= 1'b0;
      init_s2_r <= 1'b0;
    end else begin
      ack_s1_r <= ack_tgl_r;
      ack_s2_r <= ack_s1_r;
      init_s1_r <= init_done_m_r;
      init_s2_r <= init_s1_r;
    end
  end
  // fields stay stable while a toggle is outstanding
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      req_tgl_r <= 1'b0;
    end else if (req_valid && req_ready) begin
      req_tgl_r <= ~req_tgl_r;
      h_write_r <= req_write;
      h_bank_r <= req_bank;
      h_row_r <= req_row;
      h_col_r <= req_col;
      h_words_r <= req_words;
      h_be_r <= req_byte_en;
    end
  end

  // ==========================================================
  // memory side: reset and level synchronisers
  logic mrst_s1_r;
  logic mrst_r;
  logic rq_s1_r;
  logic rq_s2_r;
  logic sr_s1_r;
  logic sr_s2_r;
  logic pd_s1_r;
  logic pd_s2_r;
  always_ff @(posedge mclk) begin
    mrst_s1_r <= rst;
    mrst_r <= mrst_s1_r;
  end
  always_ff @(posedge mclk) begin
    if (mrst_r) begin
      rq_s1_r <= 1'b0;
      rq_s2_r <= 1'b0;
      sr_s1_r <= 1'b0;
      sr_s2_r <= 1'b0;
      pd_s1_r <= 1'b0;
      pd_s2_r <= 1'b0;
    end else begin
      rq_s1_r <= req_tgl_r;
      rq_s2_r <= rq_s1_r;
      sr_s1_r <= self_refresh_req;
      sr_s2_r <= sr_s1_r;
      pd_s1_r <= power_down_req;
      pd_s2_r <= pd_s1_r;
    end
  end
  assign mem_clock_out = mclk;
  // ==========================================================
  // refresh interval counter
  logic [DCS_REF_W-1:0] ref_cnt_r;
  logic ref_pend_r;
  logic ref_issue;
  always_ff @(posedge mclk) begin
    if (mrst_r) begin
      ref_cnt_r <= '0;
      ref_pend_r <= 1'b0;
    end else begin
      if (ref_cnt_r == '0) begin
        ref_cnt_r <= refresh_interval;
        ref_pend_r <= init_done_m_r | ref_pend_r;
      end else begin
        ref_cnt_r <= ref_cnt_r - 1'b1;
        if (ref_issue) begin
          ref_pend_r <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // command state machine
  dcs_state_t state_r;
  dcs_state_t ret_r;
  logic [DCS_CNT_W-1:0] gap_r;
  logic sr_mode_r;
  logic a_write_r;
  logic [DCS_BA_W-1:0] a_bank_r;
  logic [DCS_ADDR_W-1:0] a_row_r;
  logic [DCS_ADDR_W-1:0] a_col_r;
  logic [3:0] a_words_r;
  logic [DCS_DQM_W-1:0] a_be_r;
  logic [3:0] cmd_r;
  logic [DCS_NUM_BANKS-1:0] open_r;
  logic [DCS_ADDR_W-1:0] open_row_r [DCS_NUM_BANKS];
  logic req_new;
  logic [DCS_ADDR_W-1:0] mode_word;
  logic [DCS_ADDR_W-1:0] emode_word;
  assign req_new = (rq_s2_r != ack_tgl_r);
  assign ref_issue = (state_r == DCS_ST_REF);
  assign {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} = cmd_r;
  assign mem_self_refresh = (state_r == DCS_ST_SELF);
  assign mode_word = DCS_ADDR_W'({cas_latency, 1'b0, DCS_MR_BL8});
  assign emode_word = DCS_ADDR_W'({DCS_EMR_AL, 3'h0});
  always_ff @(posedge mclk) begin
    if (mrst_r) begin
      state_r <= DCS_ST_RST_PALL;
      gap_r <= '0;
      sr_mode_r <= 1'b0;
      cmd_r <= DCS_CMD_NOP;
      mem_cke <= 1'b1;
      bank_select <= '0;
      mem_addr <= '0;
      ack_tgl_r <= 1'b0;
      init_done_m_r <= 1'b0;
    end else begin
      cmd_r <= DCS_CMD_NOP;
      case (state_r)
        DCS_ST_RST_PALL, DCS_ST_INIT_PALL, DCS_ST_REF_PALL: begin
          cmd_r <= DCS_CMD_PRE;
          mem_addr <= DCS_ADDR_W'(1) << DCS_AP_BIT;
          gap_r <= RP_GAP;
          state_r <= DCS_ST_WAIT;
          if (state_r == DCS_ST_RST_PALL) begin
            ret_r <= DCS_ST_MRS;
          end else if (state_r == DCS_ST_INIT_PALL) begin
            ret_r <= DCS_ST_IDLE;
            init_done_m_r <= 1'b1;
          end else begin
            ret_r <= DCS_ST_REF;
          end
        end
        DCS_ST_MRS: begin
          cmd_r <= DCS_CMD_MRS;
          bank_select <= DCS_MR_SEL;
          mem_addr <= mode_word;
          gap_r <= MRD_GAP;
          ret_r <= DCS_ST_EMRS;
          state_r <= DCS_ST_WAIT;
        end
        DCS_ST_EMRS: begin
          cmd_r <= DCS_CMD_MRS;
          bank_select <= DCS_EMR_SEL;
          mem_addr <= emode_word;
          gap_r <= MRD_GAP;
          ret_r <= DCS_ST_INIT_PALL;
          state_r <= DCS_ST_WAIT;
        end
        DCS_ST_IDLE: begin
          if (ref_pend_r) begin
            sr_mode_r <= 1'b0;
            state_r <= DCS_ST_REF_PALL;
          end else if (sr_s2_r) begin
            sr_mode_r <= 1'b1;
            state_r <= DCS_ST_REF_PALL;
          end else if (req_new) begin
            ack_tgl_r <= rq_s2_r;
            a_write_r <= h_write_r;
            a_bank_r <= h_bank_r;
            a_row_r <= h_row_r;
            a_col_r <= h_col_r;
            a_words_r <= h_words_r;
            a_be_r <= h_be_r;
            if (!open_r[h_bank_r]) begin
              state_r <= DCS_ST_ACT;
            end else if (open_row_r[h_bank_r] != h_row_r) begin
              state_r <= DCS_ST_PRE_ONE;
            end else begin
              state_r <= DCS_ST_XFER;
            end
          end else if (pd_s2_r) begin
            mem_cke <= 1'b0;
            state_r <= DCS_ST_PDN;
          end
        end
        DCS_ST_REF: begin
          cmd_r <= DCS_CMD_REF;
          if (sr_mode_r) begin
            mem_cke <= 1'b0;
            state_r <= DCS_ST_SELF;
          end else begin
            gap_r <= RFC_GAP;
            ret_r <= DCS_ST_IDLE;
            state_r <= DCS_ST_WAIT;
          end
        end
        DCS_ST_SELF: begin
          cmd_r <= DCS_CMD_DESEL;
          if (!sr_s2_r) begin
            mem_cke <= 1'b1;
            gap_r <= XSR_GAP;
            ret_r <= DCS_ST_IDLE;
            state_r <= DCS_ST_WAIT;
          end
        end
        DCS_ST_PDN: begin
          if (!pd_s2_r || ref_pend_r || req_new || sr_s2_r) begin
            mem_cke <= 1'b1;
            gap_r <= XP_GAP;
            ret_r <= DCS_ST_IDLE;
            state_r <= DCS_ST_WAIT;
          end
        end
        DCS_ST_PRE_ONE: begin
          cmd_r <= DCS_CMD_PRE;
          bank_select <= a_bank_r;
          mem_addr <= '0;
          gap_r <= RP_GAP;
          ret_r <= DCS_ST_ACT;
          state_r <= DCS_ST_WAIT;
        end
        DCS_ST_ACT: begin
          cmd_r <= DCS_CMD_ACT;
          bank_select <= a_bank_r;
          mem_addr <= a_row_r;
          gap_r <= RCD_GAP;
          ret_r <= DCS_ST_XFER;
          state_r <= DCS_ST_WAIT;
        end
        DCS_ST_XFER: begin
          cmd_r <= a_write_r ? DCS_CMD_WR : DCS_CMD_RD;
          bank_select <= a_bank_r;
          mem_addr <= a_col_r & ~(DCS_ADDR_W'(1) << DCS_AP_BIT);
          gap_r <= DCS_CNT_W'({cas_latency, 1'b0}) + DCS_CNT_W'(DCS_BURST_CLK);
          ret_r <= DCS_ST_IDLE;
          state_r <= DCS_ST_WAIT;
        end
        DCS_ST_WAIT: begin
          if (gap_r <= GAP_ONE) begin
            state_r <= ret_r;
          end else begin
            gap_r <= gap_r - 1'b1;
          end
        end
        default: begin
          state_r <= DCS_ST_RST_PALL;
        end
      endcase
    end
  end

  // ==========================================================
  // open page table
  always_ff @(posedge mclk) begin
    if (mrst_r) begin
      open_r <= '0;
    end else begin
      case (state_r)
        DCS_ST_RST_PALL, DCS_ST_INIT_PALL, DCS_ST_REF_PALL, DCS_ST_REF: begin
          open_r <= '0;
        end
        DCS_ST_PRE_ONE: begin
          open_r[a_bank_r] <= 1'b0;
        end
        DCS_ST_ACT: begin
          open_r[a_bank_r] <= 1'b1;
        end
        default: open_r <= open_r;
      endcase
    end
  end
  always_ff @(posedge mclk) begin
    if (state_r == DCS_ST_ACT) begin
      open_row_r[a_bank_r] <= a_row_r;
    end
  end
  // ==========================================================
  // data windows after read and write commands
  logic win_on_r;
  logic win_wr_r;
  logic [4:0] win_age_r;
  logic [4:0] win_lat_r;
  logic [3:0] win_words_r;
  logic [DCS_DQM_W-1:0] win_be_r;
  logic [4:0] age_nxt;
  logic [4:0] pos;
  logic in_win;
  logic [3:0] beat0;
  assign age_nxt = win_age_r + 5'h01;
  assign pos = age_nxt - win_lat_r;
  assign in_win = win_on_r && (age_nxt >= win_lat_r) && (pos < BURST_CLK5);
  assign beat0 = {pos[2:0], 1'b0};
  always_ff @(posedge mclk) begin
    if (mrst_r) begin
      win_on_r <= 1'b0;
    end else if (state_r == DCS_ST_XFER) begin
      win_on_r <= 1'b1;
      win_wr_r <= a_write_r;
      win_age_r <= '0;
      // read at the column latency, write one cycle earlier
      win_lat_r <= a_write_r ? 5'(cas_latency) - 5'h01 : 5'(cas_latency);
      win_words_r <= a_words_r;
      win_be_r <= a_be_r;
    end else if (win_on_r) begin
      win_age_r <= age_nxt;
      if (age_nxt >= win_lat_r + BURST_CLK5) begin
        win_on_r <= 1'b0;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (mrst_r) begin
      mem_dq_oe <= 1'b0;
      mem_wdata_req <= 1'b0;
      mem_dqm_rise <= '1;
      mem_dqm_fall <= '1;
      mem_rd_valid <= 1'b0;
      mem_rd_keep <= '0;
      mem_beat_idx <= '0;
    end else begin
      mem_dq_oe <= in_win && win_wr_r;
      mem_wdata_req <= in_win && win_wr_r;
      mem_rd_valid <= in_win && !win_wr_r;
      mem_beat_idx <= in_win ? beat0[2:0] : 3'h0;
      // surplus beats of a short write are masked
      mem_dqm_rise <= (in_win && win_wr_r && (beat0 < win_words_r)) ? ~win_be_r : '1;
      mem_dqm_fall <= (in_win && win_wr_r && (beat0 + 4'h1 < win_words_r)) ? ~win_be_r : '1;
      // beats past the request are flagged for discard
      mem_rd_keep <= (in_win && !win_wr_r) ?
        {(beat0 + 4'h1 < win_words_r), (beat0 < win_words_r)} : 2'h0;
    end
  end
endmodule
`default_nettype wire

// ===== test/dcs_sequencer_assertions.sv
// concurrent checks on the command, mode-word and data-window outputs of the sequencer
`timescale 1ns/100ps
`default_nettype none
module dcs_sequencer_assertions
  import dcs_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic init_done,
  input wire logic [2:0] cas_latency,
  input wire logic mem_cke,
  input wire logic mem_cs_n,
  input wire logic mem_ras_n,
  input wire logic mem_cas_n,
  input wire logic mem_we_n,
  input wire logic [DCS_BA_W-1:0] bank_select,
  input wire logic [DCS_ADDR_W-1:0] mem_addr,
  input wire logic mem_rd_valid,
  input wire logic mem_dq_oe
);
  // ==========================================
  // helper state: open banks and age of last access
  logic [3:0] cmd;
  logic [DCS_NUM_BANKS-1:0] open_r;
  logic [7:0] age_r;
  logic [7:0] cl8;
  logic rd_r;
  logic rd_win;
  logic wr_win;
  assign cmd = {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n};
  assign cl8 = {5'h00, cas_latency};
  assign rd_win = rd_r && age_r >= cl8 && age_r <= cl8 + 8'h03;
  assign wr_win = !rd_r && age_r >= cl8 - 8'h01 && age_r <= cl8 + 8'h02;
  always_ff @(posedge mclk) begin
    if (rst) begin
      open_r <= '0;
    end else if (cmd == DCS_CMD_PRE && mem_addr[DCS_AP_BIT]) begin
      open_r <= '0;
    end else if (cmd == DCS_CMD_PRE) begin
      open_r[bank_select] <= 1'b0;
    end else if (cmd == DCS_CMD_ACT) begin
      open_r[bank_select] <= 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      age_r <= 8'hff;
      rd_r <= 1'b0;
    end else if (cmd == DCS_CMD_RD || cmd == DCS_CMD_WR) begin
      age_r <= 8'h01;
      rd_r <= (cmd == DCS_CMD_RD);
    end else if (age_r != 8'hff) begin
      age_r <= age_r + 8'h01;
    end
  end
  // ==========================================
  // assertions
  a_ref_all_closed: assert property (@(posedge mclk) disable iff (rst)
    cmd == DCS_CMD_REF |-> open_r == '0) else $error("refresh with a bank open");
  a_mode_all_closed: assert property (@(posedge mclk) disable iff (rst)
    cmd == DCS_CMD_MRS |-> open_r == '0) else $error("mode set with a bank open");
  a_mode_only_init: assert property (@(posedge mclk) disable iff (rst)
    cmd == DCS_CMD_MRS |-> !init_done) else $error("mode set after init");
  a_mode_word_ok: assert property (@(posedge mclk) disable iff (rst)
    cmd == DCS_CMD_MRS |-> (bank_select == DCS_MR_SEL && mem_addr[2:0] == DCS_MR_BL8
    && mem_addr[6:4] == cas_latency) || (bank_select == DCS_EMR_SEL
    && mem_addr[5:3] == DCS_EMR_AL)) else $error("bad mode word");
  a_access_open_row: assert property (@(posedge mclk) disable iff (rst)
    (cmd == DCS_CMD_RD || cmd == DCS_CMD_WR) |-> open_r[bank_select]
    && !mem_addr[DCS_AP_BIT]) else $error("access to closed bank");
  a_act_closed_bank: assert property (@(posedge mclk) disable iff (rst)
    cmd == DCS_CMD_ACT |-> !open_r[bank_select]) else $error("second open row in bank");
  a_read_window: assert property (@(posedge mclk) disable iff (rst)
    mem_rd_valid == rd_win) else $error("read window misplaced");
  a_write_window: assert property (@(posedge mclk) disable iff (rst)
    mem_dq_oe == wr_win) else $error("write window misplaced");
  a_quiet_after_access: assert property (@(posedge mclk) disable iff (rst)
    (cmd == DCS_CMD_RD || cmd == DCS_CMD_WR) |=> (cmd == DCS_CMD_NOP) [*7])
    else $error("command inside burst gap");
  a_cke_drop_cmd: assert property (@(posedge mclk) disable iff (rst)
    $fell(mem_cke) |-> cmd == DCS_CMD_REF || cmd == DCS_CMD_NOP || cmd[3])
    else $error("clock enable dropped with bad command");
  c_read: cover property (@(posedge mclk) disable iff (rst) cmd == DCS_CMD_RD);
  c_write: cover property (@(posedge mclk) disable iff (rst) cmd == DCS_CMD_WR);
  c_refresh: cover property (@(posedge mclk) disable iff (rst) cmd == DCS_CMD_REF);
  c_cke_low: cover property (@(posedge mclk) disable iff (rst) $fell(mem_cke));
endmodule
bind dcs_sequencer dcs_sequencer_assertions i_dcs_sequencer_assertions (.mclk, .rst,
  .init_done, .cas_latency, .mem_cke, .mem_cs_n, .mem_ras_n, .mem_cas_n, .mem_we_n,
  .bank_select, .mem_addr, .mem_rd_valid, .mem_dq_oe);
`default_nettype wire

// ===== test/dcs_mem_model.sv
// behavioural memory device: captures commands and mode words, counts protocol faults
`timescale 1ns/100ps
`default_nettype none
module dcs_mem_model
  import dcs_pkg::*;
(
  input wire logic mem_clock_out,
  input wire logic mem_cke,
  input wire logic mem_cs_n,
  input wire logic mem_ras_n,
  input wire logic mem_cas_n,
  input wire logic mem_we_n,
  input wire logic [DCS_BA_W-1:0] bank_select,
  input wire logic [DCS_ADDR_W-1:0] mem_addr,
  output logic [2:0] mr_burst,
  output logic [2:0] mr_cl,
  output logic [2:0] emr_al,
  output logic [7:0] fault_cnt
);
  logic [DCS_NUM_BANKS-1:0] open_r;
  initial begin
    {mr_burst, mr_cl, emr_al, fault_cnt} = 17'h00000;
    open_r = '0;
  end
  always @(posedge mem_clock_out) begin
    if (mem_cke) begin
      case ({mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n})
        DCS_CMD_MRS: begin
          if (bank_select == DCS_MR_SEL) begin
            mr_burst = mem_addr[2:0];
            mr_cl = mem_addr[6:4];
          end else begin
            emr_al = mem_addr[5:3];
          end
        end
        DCS_CMD_ACT: begin
          if (open_r[bank_select]) fault_cnt++;
          open_r[bank_select] = 1'b1;
        end
        DCS_CMD_PRE: begin
          if (mem_addr[DCS_AP_BIT]) open_r = '0;
          else open_r[bank_select] = 1'b0;
        end
        DCS_CMD_RD, DCS_CMD_WR: if (!open_r[bank_select]) fault_cnt++;
        DCS_CMD_REF: if (open_r != '0) fault_cnt++;
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== test/dcs_sequencer_tb.sv
// self-checking testbench for the ddr2 command sequencer
`timescale 1ns/100ps
`default_nettype none
module dcs_sequencer_tb;
  import dcs_pkg::*;
  localparam logic [2:0] CL = 3'h3;
  localparam logic [12:0] REF_IVL = 13'h0100;
  logic clk_sys = 1'b0, mclk = 1'b0, rst = 1'b1;
  logic req_valid = 1'b0, req_write = 1'b0, self_refresh_req = 1'b0, power_down_req = 1'b0;
  logic [2:0] req_bank = 3'h0;
  logic [12:0] req_row = 13'h0000, req_col = 13'h0000;
  logic [3:0] req_words = 4'h1, req_byte_en = 4'h5;
  logic req_ready, init_done, mem_clock_out, mem_cke, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n;
  logic mem_dq_oe, mem_wdata_req, mem_rd_valid, mem_self_refresh, pre_a10;
  logic [2:0] bank_select, mem_beat_idx, mr_burst, mr_cl, emr_al, pre_bank, bank_seen;
  logic [12:0] mem_addr, col_seen;
  logic [3:0] mem_dqm_rise, mem_dqm_fall, cmd;
  logic [1:0] mem_rd_keep;
  logic [7:0] fault_cnt;
  int num_errors = 0, comparisons = 0, act_n = 0, pre_n = 0, ref_n = 0, keep_n = 0;
  int wbeat_n = 0, win_n = 0, mclk_n = 0, ref_at = 0, ref_gap = 0, beat_sum = 0;
  always #5 clk_sys = ~clk_sys;
  initial begin
    #3;
    forever #80 mclk = ~mclk;
  end
  dcs_sequencer i_dcs_sequencer (.clk_sys, .rst, .req_valid, .req_ready, .req_write,
    .req_bank, .req_row, .req_col, .req_words, .req_byte_en, .self_refresh_req,
    .power_down_req, .init_done, .mclk, .cas_latency(CL), .refresh_interval(REF_IVL),
    .mem_clock_out, .mem_cke, .mem_cs_n, .mem_ras_n, .mem_cas_n, .mem_we_n, .bank_select,
    .mem_addr, .mem_dqm_rise, .mem_dqm_fall, .mem_dq_oe, .mem_wdata_req, .mem_beat_idx,
    .mem_rd_valid, .mem_rd_keep, .mem_self_refresh);
  dcs_mem_model i_dcs_mem_model (.mem_clock_out, .mem_cke, .mem_cs_n, .mem_ras_n,
    .mem_cas_n, .mem_we_n, .bank_select, .mem_addr, .mr_burst, .mr_cl, .emr_al, .fault_cnt);
  // ==========================================
  // link monitor
  assign cmd = {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n};
  always @(posedge mclk) begin
    mclk_n++;
    if (cmd == DCS_CMD_ACT) act_n++;
    if (cmd == DCS_CMD_PRE) begin
      pre_n++;
      pre_bank = bank_select;
      pre_a10 = mem_addr[DCS_AP_BIT];
    end
    if (cmd == DCS_CMD_REF && mem_cke) begin
      ref_n++;
      ref_gap = mclk_n - ref_at;
      ref_at = mclk_n;
    end
    if (cmd == DCS_CMD_RD || cmd == DCS_CMD_WR) {col_seen, bank_seen} = {mem_addr, bank_select};
    if (mem_rd_valid) begin
      win_n++;
      keep_n += mem_rd_keep[0] + mem_rd_keep[1];
    end
    if (mem_dq_oe && mem_wdata_req) begin
      win_n++;
      wbeat_n += (mem_dqm_rise == ~req_byte_en) + (mem_dqm_fall == ~req_byte_en);
    end
    if (mem_rd_valid || mem_dq_oe) beat_sum += mem_beat_idx;
  end
  // ==========================================
  // shared tasks
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic expire();
    num_errors++;
    $display("unexpected timeout at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    complete_run();
  endtask
  task automatic wait_ref();
    int r;
    int i;
    r = ref_n;
    for (i = 0; i < 400 && ref_n == r; i++) @(posedge mclk);
    if (ref_n == r) expire();
  endtask
  task automatic wait_cke(input logic v);
    int i;
    for (i = 0; i < 4000 && mem_cke !== v; i++) @(negedge clk_sys);
    if (mem_cke !== v) expire();
  endtask
  task automatic access(input logic w, input logic [2:0] b, input logic [12:0] r,
      input logic [3:0] n, input int acts, input int pres);
    int i;
    {act_n, pre_n, keep_n, wbeat_n, win_n, beat_sum} = '0;
    for (i = 0; i < 400 && req_ready !== 1'b1; i++) @(negedge clk_sys);
    if (req_ready !== 1'b1) expire();
    {req_write, req_bank, req_row, req_col, req_words} = {w, b, r, {3'h0, r[1:0], 8'h10}, n};
    req_valid = 1'b1;
    @(negedge clk_sys);
    req_valid = 1'b0;
    for (i = 0; i < 400 && win_n < 4; i++) @(posedge mclk);
    if (win_n < 4) expire();
    repeat (4) @(posedge mclk);
    check(win_n[15:0], 16'h0004);
    check(beat_sum[15:0], 16'h000c);
    check(w ? wbeat_n[15:0] : keep_n[15:0], {12'h000, n});
    check({bank_seen, col_seen}, {b, 3'h0, r[1:0], 8'h10});
    check(act_n[15:0], acts[15:0]);
    check(pre_n[15:0], pres[15:0]);
    check(fault_cnt, 16'h0000);
  endtask
  // ==========================================
  // scenarios
  task automatic s_init();
    int i;
    for (i = 0; i < 2000 && init_done !== 1'b1; i++) @(negedge clk_sys);
    if (init_done !== 1'b1) expire();
    check(init_done, 16'h0001);
    check(pre_n[15:0], 16'h0002);
    check({mr_burst, mr_cl, emr_al}, {DCS_MR_BL8, CL, DCS_EMR_AL});
  endtask
  task automatic s_read_pages();
    wait_ref();
    access(1'b0, 3'h2, 13'h0005, 4'h3, 1, 0);
    access(1'b0, 3'h2, 13'h0005, 4'h8, 0, 0);
    access(1'b0, 3'h2, 13'h0006, 4'h1, 1, 1);
    check({pre_bank, pre_a10}, {3'h2, 1'b0});
  endtask
  task automatic s_write_mask();
    wait_ref();
    access(1'b1, 3'h4, 13'h0001, 4'h3, 1, 0);
    access(1'b1, 3'h4, 13'h0001, 4'h8, 0, 0);
  endtask
  task automatic s_refresh();
    wait_ref();
    check(pre_a10, 1'b1);
    wait_ref();
    check(ref_gap >= REF_IVL && ref_gap <= REF_IVL + 8, 1'b1);
    access(1'b0, 3'h4, 13'h0001, 4'h2, 1, 0);
  endtask
  task automatic s_low_power();
    @(negedge clk_sys);
    self_refresh_req = 1'b1;
    wait_cke(1'b0);
    repeat (40) @(negedge clk_sys);
    check({mem_self_refresh, mem_cke}, 2'h2);
    self_refresh_req = 1'b0;
    wait_cke(1'b1);
    power_down_req = 1'b1;
    wait_cke(1'b0);
    repeat (40) @(negedge clk_sys);
    check({mem_self_refresh, cmd == DCS_CMD_NOP || cmd[3]}, 2'h1);
    power_down_req = 1'b0;
    wait_cke(1'b1);
    access(1'b0, 3'h4, 13'h0001, 4'h4, 1, 0);
  endtask
  initial begin
    repeat (50) @(negedge clk_sys);
    rst = 1'b0;
    s_init();
    s_read_pages();
    s_write_mask();
    s_refresh();
    s_low_power();
    complete_run();
  end
endmodule
`default_nettype wire
